// [rtl/mfcr_pkg.sv]
package mfcr_pkg;

  // Register bus geometry
  localparam int ADDR_W = 11;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [10:0] OFS_TEMP_AVG = 11'h4B6;
  localparam logic [10:0] OFS_TEMP_READING = 11'h4B7;
  localparam logic [10:0] OFS_AMP_GAINS = 11'h4B9;
  localparam logic [10:0] OFS_CONV_SHUTOFF = 11'h4BA;
  localparam logic [10:0] OFS_REACTIVE_OFF = 11'h4E0;

  // Implemented bit masks, writable except the read-only temperature reading; reserved bits are zero here
  localparam logic [15:0] MASK_TEMP_AVG = 16'h0003;
  localparam logic [15:0] MASK_TEMP_READING = 16'h0FFF;
  localparam logic [15:0] MASK_AMP_GAINS = 16'h3FFF;
  localparam logic [15:0] MASK_CONV_SHUTOFF = 16'h007F;
  localparam logic [15:0] MASK_REACTIVE_OFF = 16'h0001;

  // Reset values
  localparam logic [1:0] RST_TEMP_AVG = 2'h0;
  localparam logic [11:0] RST_TEMP_READING = 12'h000;
  localparam logic [13:0] RST_AMP_GAINS = 14'h0000;
  localparam logic [6:0] RST_CONV_SHUTOFF = 7'h00;
  localparam logic RST_REACTIVE_OFF = 1'b0;

  // Gain field positions (low bit of each 2-bit field)
  localparam int POS_CURR_A_GAIN = 0;
  localparam int POS_CURR_B_GAIN = 2;
  localparam int POS_CURR_C_GAIN = 4;
  localparam int POS_NEUTRAL_GAIN = 6;
  localparam int POS_VOLT_A_GAIN = 8;
  localparam int POS_VOLT_B_GAIN = 10;
  localparam int POS_VOLT_C_GAIN = 12;

  // Converter shutoff bit positions
  localparam int POS_CURR_A_OFF = 0;
  localparam int POS_CURR_B_OFF = 1;
  localparam int POS_CURR_C_OFF = 2;
  localparam int POS_NEUTRAL_OFF = 3;
  localparam int POS_VOLT_A_OFF = 4;
  localparam int POS_VOLT_B_OFF = 5;
  localparam int POS_VOLT_C_OFF = 6;

  // Temperature sampling: one reading per millisecond
  localparam int TEMP_TICK_NS = 1000000;
  localparam int CLK_FREQ_MHZ = 200;
  localparam int TEMP_TICK_CYCLES = TEMP_TICK_NS * CLK_FREQ_MHZ / 1000;

  // Averaging selects
  localparam logic [1:0] AVG_1 = 2'h0;
  localparam logic [1:0] AVG_256 = 2'h1;
  localparam logic [1:0] AVG_512 = 2'h2;
  localparam logic [1:0] AVG_1024 = 2'h3;

  // Log2 of sample counts per select
  localparam logic [3:0] LOG2_AVG_1 = 4'h0;
  localparam logic [3:0] LOG2_AVG_256 = 4'h8;
  localparam logic [3:0] LOG2_AVG_512 = 4'h9;
  localparam logic [3:0] LOG2_AVG_1024 = 4'hA;

  localparam int ACC_W = 22;
  localparam int CNT_W = 11;

endpackage

// [rtl/mfcr_regs.sv]
// Notes on behaviour
// - Averaging select 2 averages 512 readings per 512 ms result, select 3 averages 1024 per 1024 ms result.
// - Averaging select 0 uses one reading per 1 ms result, select 1 averages 256 per 256 ms result.
// - The temperature result reads as 12 bits in 11:0 with bits 15:12 reading zero.
// - The voltage C gain field sits in 13:12, code 0 gives gain 1, code 1 gain 2, codes 2 and 3 gain 4.
// - The other gain fields use the same codes at 11:10, 9:8, 7:6, 5:4, 3:2 and 1:0, with 15:14 reserved.
// - Each set bit 6 to 0 of the shutoff register turns off one converter, bits 15:7 reserved.
// - Bit 0 of the reactive register stops the total reactive power calculation, bits 15:1 reserved.
`timescale 1ns/1ps

module mfcr_regs #(
  parameter int TICK_CYCLES = mfcr_pkg::TEMP_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [mfcr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mfcr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [mfcr_pkg::DATA_W-1:0] reg_rdata,
  // Temperature sensor converter output
  input wire logic [11:0] temp_sensor_value,
  output logic temp_reading_fresh,
  // Amplifier gain codes
  output logic [1:0] volt_c_amp_setting,
  output logic [1:0] volt_b_amp_setting,
  output logic [1:0] volt_a_amp_setting,
  output logic [1:0] neutral_amp_setting,
  output logic [1:0] curr_c_amp_setting,
  output logic [1:0] curr_b_amp_setting,
  output logic [1:0] curr_a_amp_setting,
  // Amplifier gain as a power of two (0 = x1, 1 = x2, 2 = x4)
  output logic [1:0] volt_c_gain_log2,
  output logic [1:0] volt_b_gain_log2,
  output logic [1:0] volt_a_gain_log2,
  output logic [1:0] neutral_gain_log2,
  output logic [1:0] curr_c_gain_log2,
  output logic [1:0] curr_b_gain_log2,
  output logic [1:0] curr_a_gain_log2,
  // Converter shutoffs
  output logic volt_c_converter_off,
  output logic volt_b_converter_off,
  output logic volt_a_converter_off,
  output logic neutral_converter_off,
  output logic curr_c_converter_off,
  output logic curr_b_converter_off,
  output logic curr_a_converter_off,
  // Reactive power calculation inhibit
  output logic reactive_total_inhibit
);

  localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  generate
    if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("TICK_CYCLES must be at least one");
    end
    // A full 1024-reading window must wrap neither the sum nor the count
    if (mfcr_pkg::ACC_W < 12 + int'(mfcr_pkg::LOG2_AVG_1024)) begin : g_bad_acc
      $error("ACC_W too narrow for the longest window");
    end
    if (mfcr_pkg::CNT_W < 1 + int'(mfcr_pkg::LOG2_AVG_1024)) begin : g_bad_cnt
      $error("CNT_W too narrow for the longest window");
    end
  endgenerate

  // Codes 2 and 3 both give gain 4
  function automatic logic [1:0] gain_log2(input logic [1:0] code);
    logic [1:0] e;
    e = 2'h2;
    if (code == 2'h0) begin
      e = 2'h0;
    end else if (code == 2'h1) begin
      e = 2'h1;
    end
    return e;
  endfunction

  function automatic logic [3:0] avg_log2(input logic [1:0] sel);
    logic [3:0] r;
    r = mfcr_pkg::LOG2_AVG_1;
    case (sel)
      mfcr_pkg::AVG_1: r = mfcr_pkg::LOG2_AVG_1;
      mfcr_pkg::AVG_256: r = mfcr_pkg::LOG2_AVG_256;
      mfcr_pkg::AVG_512: r = mfcr_pkg::LOG2_AVG_512;
      default: r = mfcr_pkg::LOG2_AVG_1024;
    endcase
    return r;
  endfunction

  // Register state
  logic [1:0] temp_avg_q;
  logic [1:0] temp_avg_d;
  logic [11:0] temp_reading_q;
  logic [11:0] temp_reading_d;
  logic [13:0] amp_gains_q;
  logic [13:0] amp_gains_d;
  logic [6:0] conv_shutoff_q;
  logic [6:0] conv_shutoff_d;
  logic reactive_off_q;
  logic reactive_off_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic fresh_q;
  logic fresh_d;

  // Averaging state
  logic [TICK_W-1:0] tick_cnt_q;
  logic [TICK_W-1:0] tick_cnt_d;
  logic [mfcr_pkg::ACC_W-1:0] acc_q;
  logic [mfcr_pkg::ACC_W-1:0] acc_d;
  logic [mfcr_pkg::CNT_W-1:0] sample_cnt_q;
  logic [mfcr_pkg::CNT_W-1:0] sample_cnt_d;

  // Address decode
  wire hit_temp_avg = (reg_addr == mfcr_pkg::OFS_TEMP_AVG);
  wire hit_temp_reading = (reg_addr == mfcr_pkg::OFS_TEMP_READING);
  wire hit_amp_gains = (reg_addr == mfcr_pkg::OFS_AMP_GAINS);
  wire hit_conv_shutoff = (reg_addr == mfcr_pkg::OFS_CONV_SHUTOFF);
  wire hit_reactive_off = (reg_addr == mfcr_pkg::OFS_REACTIVE_OFF);

  wire wr_temp_avg = reg_write && hit_temp_avg;
  wire wr_amp_gains = reg_write && hit_amp_gains;
  wire wr_conv_shutoff = reg_write && hit_conv_shutoff;
  wire wr_reactive_off = reg_write && hit_reactive_off;

  // Read views; reserved bits are tied to zero here
  wire [15:0] view_temp_avg = {14'h0000, temp_avg_q};
  wire [15:0] view_temp_reading = {4'h0, temp_reading_q};
  wire [15:0] view_amp_gains = {2'h0, amp_gains_q};
  wire [15:0] view_conv_shutoff = {9'h000, conv_shutoff_q};
  wire [15:0] view_reactive_off = {15'h0000, reactive_off_q};

  // Read mux; unmapped addresses read zero
  logic [15:0] rd_mux;
  always_comb begin
    if (hit_temp_avg) begin
      rd_mux = view_temp_avg;
    end else if (hit_temp_reading) begin
      rd_mux = view_temp_reading;
    end else if (hit_amp_gains) begin
      rd_mux = view_amp_gains;
    end else if (hit_conv_shutoff) begin
      rd_mux = view_conv_shutoff;
    end else if (hit_reactive_off) begin
      rd_mux = view_reactive_off;
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // Reserved bits are dropped before they reach storage
  function automatic logic [15:0] keep_bits(input logic [15:0] data, input logic [15:0] mask);
    return data & mask;
  endfunction

  wire [15:0] wdata_avg = keep_bits(reg_wdata, mfcr_pkg::MASK_TEMP_AVG);
  wire [15:0] wdata_gains = keep_bits(reg_wdata, mfcr_pkg::MASK_AMP_GAINS);
  wire [15:0] wdata_shutoff = keep_bits(reg_wdata, mfcr_pkg::MASK_CONV_SHUTOFF);
  wire [15:0] wdata_reactive = keep_bits(reg_wdata, mfcr_pkg::MASK_REACTIVE_OFF);

  // Next values: a register moves only on a write to its own offset
  assign temp_avg_d = wr_temp_avg ? wdata_avg[1:0] : temp_avg_q;
  assign amp_gains_d = wr_amp_gains ? wdata_gains[13:0] : amp_gains_q;
  assign conv_shutoff_d = wr_conv_shutoff ? wdata_shutoff[6:0] : conv_shutoff_q;
  assign reactive_off_d = wr_reactive_off ? wdata_reactive[0] : reactive_off_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      temp_avg_q <= mfcr_pkg::RST_TEMP_AVG;
    end else begin
      temp_avg_q <= temp_avg_d;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      amp_gains_q <= mfcr_pkg::RST_AMP_GAINS;
    end else begin
      amp_gains_q <= amp_gains_d;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      conv_shutoff_q <= mfcr_pkg::RST_CONV_SHUTOFF;
    end else begin
      conv_shutoff_q <= conv_shutoff_d;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reactive_off_q <= mfcr_pkg::RST_REACTIVE_OFF;
    end else begin
      reactive_off_q <= reactive_off_d;
    end
  end

  // Read data stand only in the cycle after the strobe
  assign rdata_d = reg_read ? rd_mux : 16'h0000;

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // One sensor reading is taken per millisecond tick
  wire tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));
  assign tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;

  always_ff @(posedge clock) begin
    if (reset) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // Sample count is a power of two, so the mean is a shift of the sum
  wire [3:0] shift = avg_log2(temp_avg_q);
  wire [mfcr_pkg::CNT_W-1:0] target = mfcr_pkg::CNT_W'(1) << shift;
  wire [mfcr_pkg::CNT_W-1:0] next_cnt = sample_cnt_q + 1'b1;
  wire [mfcr_pkg::ACC_W-1:0] sum = acc_q + {10'h000, temp_sensor_value};
  wire [mfcr_pkg::ACC_W-1:0] mean = sum >> shift;
  wire window_done = tick && (next_cnt == target);

  // A new select restarts the window so no result mixes two settings
  wire restart = wr_temp_avg || window_done;
  assign acc_d = restart ? '0 : (tick ? sum : acc_q);
  assign sample_cnt_d = restart ? '0 : (tick ? next_cnt : sample_cnt_q);

  always_ff @(posedge clock) begin
    if (reset) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sample_cnt_q <= '0;
    end else begin
      sample_cnt_q <= sample_cnt_d;
    end
  end

  // A window that ends beside a select write is dropped, never published
  wire publish = window_done && !wr_temp_avg;
  assign temp_reading_d = publish ? mean[11:0] : temp_reading_q;
  assign fresh_d = publish;

  always_ff @(posedge clock) begin
    if (reset) begin
      temp_reading_q <= mfcr_pkg::RST_TEMP_READING;
    end else begin
      temp_reading_q <= temp_reading_d;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      fresh_q <= 1'b0;
    end else begin
      fresh_q <= fresh_d;
    end
  end

  // Outputs
  assign reg_rdata = rdata_q;
  assign temp_reading_fresh = fresh_q;

  assign volt_c_amp_setting = amp_gains_q[mfcr_pkg::POS_VOLT_C_GAIN +: 2];
  assign volt_b_amp_setting = amp_gains_q[mfcr_pkg::POS_VOLT_B_GAIN +: 2];
  assign volt_a_amp_setting = amp_gains_q[mfcr_pkg::POS_VOLT_A_GAIN +: 2];
  assign neutral_amp_setting = amp_gains_q[mfcr_pkg::POS_NEUTRAL_GAIN +: 2];
  assign curr_c_amp_setting = amp_gains_q[mfcr_pkg::POS_CURR_C_GAIN +: 2];
  assign curr_b_amp_setting = amp_gains_q[mfcr_pkg::POS_CURR_B_GAIN +: 2];
  assign curr_a_amp_setting = amp_gains_q[mfcr_pkg::POS_CURR_A_GAIN +: 2];

  assign volt_c_gain_log2 = gain_log2(volt_c_amp_setting);
  assign volt_b_gain_log2 = gain_log2(volt_b_amp_setting);
  assign volt_a_gain_log2 = gain_log2(volt_a_amp_setting);
  assign neutral_gain_log2 = gain_log2(neutral_amp_setting);
  assign curr_c_gain_log2 = gain_log2(curr_c_amp_setting);
  assign curr_b_gain_log2 = gain_log2(curr_b_amp_setting);
  assign curr_a_gain_log2 = gain_log2(curr_a_amp_setting);

  assign volt_c_converter_off = conv_shutoff_q[mfcr_pkg::POS_VOLT_C_OFF];
  assign volt_b_converter_off = conv_shutoff_q[mfcr_pkg::POS_VOLT_B_OFF];
  assign volt_a_converter_off = conv_shutoff_q[mfcr_pkg::POS_VOLT_A_OFF];
  assign neutral_converter_off = conv_shutoff_q[mfcr_pkg::POS_NEUTRAL_OFF];
  assign curr_c_converter_off = conv_shutoff_q[mfcr_pkg::POS_CURR_C_OFF];
  assign curr_b_converter_off = conv_shutoff_q[mfcr_pkg::POS_CURR_B_OFF];
  assign curr_a_converter_off = conv_shutoff_q[mfcr_pkg::POS_CURR_A_OFF];

  // Engine samples this level when it starts; setting it later is unsafe
  assign reactive_total_inhibit = reactive_off_q;

endmodule

// [sim/mfcr_regs_properties.sv]
`timescale 1ns/1ps
module mfcr_regs_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [10:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // Watched outputs
  input wire logic temp_reading_fresh,
  input wire logic [1:0] volt_c_amp_setting,
  input wire logic [1:0] curr_a_amp_setting,
  input wire logic [1:0] volt_c_gain_log2,
  input wire logic [1:0] curr_a_gain_log2,
  input wire logic volt_c_converter_off,
  input wire logic curr_a_converter_off,
  input wire logic reactive_total_inhibit
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire wr_gain = reg_write && reg_addr == mfcr_pkg::OFS_AMP_GAINS;
  wire wr_shut = reg_write && reg_addr == mfcr_pkg::OFS_CONV_SHUTOFF;
  wire wr_react = reg_write && reg_addr == mfcr_pkg::OFS_REACTIVE_OFF;
  property p_gain_wr;
    wr_gain |=> {volt_c_amp_setting, curr_a_amp_setting} == {$past(reg_wdata[13:12]), $past(reg_wdata[1:0])};
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("gain field not taken from write");
  property p_decode;
    volt_c_gain_log2 == (volt_c_amp_setting[1] ? 2'h2 : volt_c_amp_setting);
  endproperty
  a_decode: assert property (p_decode) else $error("voltage C gain decode wrong");
  property p_decode_a;
    curr_a_gain_log2 == (curr_a_amp_setting[1] ? 2'h2 : curr_a_amp_setting);
  endproperty
  a_decode_a: assert property (p_decode_a) else $error("current A gain decode wrong");
  property p_shut_wr;
    wr_shut |=> {volt_c_converter_off, curr_a_converter_off} == {$past(reg_wdata[6]), $past(reg_wdata[0])};
  endproperty
  a_shut_wr: assert property (p_shut_wr) else $error("shutoff bits not taken from write");
  property p_shut_hold;
    !wr_shut |=> $stable({volt_c_converter_off, curr_a_converter_off});
  endproperty
  a_shut_hold: assert property (p_shut_hold) else $error("shutoff changed without write");
  property p_react;
    wr_react |=> reactive_total_inhibit == $past(reg_wdata[0]);
  endproperty
  a_react: assert property (p_react) else $error("reactive inhibit not taken");
  property p_rdata_idle;
    !reg_read |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_temp_rsv;
    reg_read && reg_addr == mfcr_pkg::OFS_TEMP_READING |=> reg_rdata[15:12] == 4'h0;
  endproperty
  a_temp_rsv: assert property (p_temp_rsv) else $error("temperature upper bits set");
  property p_fresh;
    temp_reading_fresh |=> !temp_reading_fresh [*3];
  endproperty
  a_fresh: assert property (p_fresh) else $error("result refresh too close");
  c_gain: cover property (wr_gain);
  c_react: cover property (wr_react ##1 reactive_total_inhibit);
  c_fresh: cover property (temp_reading_fresh);
endmodule
bind mfcr_regs mfcr_regs_properties i_props (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .temp_reading_fresh, .volt_c_amp_setting, .curr_a_amp_setting, .volt_c_gain_log2,
  .curr_a_gain_log2, .volt_c_converter_off, .curr_a_converter_off, .reactive_total_inhibit);

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
  localparam int TICK = 4;
  logic clock = 0, reset = 1, reg_write = 0, reg_read = 0, temp_reading_fresh;
  logic [10:0] reg_addr = 11'h000;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
  logic [11:0] temp_sensor_value = 12'h000;
  logic [1:0] volt_c_amp_setting, volt_b_amp_setting, volt_a_amp_setting, neutral_amp_setting;
  logic [1:0] curr_c_amp_setting, curr_b_amp_setting, curr_a_amp_setting;
  logic [1:0] volt_c_gain_log2, volt_b_gain_log2, volt_a_gain_log2, neutral_gain_log2;
  logic [1:0] curr_c_gain_log2, curr_b_gain_log2, curr_a_gain_log2;
  logic volt_c_converter_off, volt_b_converter_off, volt_a_converter_off, neutral_converter_off;
  logic curr_c_converter_off, curr_b_converter_off, curr_a_converter_off, reactive_total_inhibit;
  logic [31:0] seed = 32'hB2FA;
  logic [15:0] r;
  int n_mismatch = 0, total_checks = 0, cycles = 0, n, m_gain, m_shut;
  int t_cnt = 0, w_cnt = 0, w_sel = 0, w_sum = 0;
  int q_exp[$];
  logic [11:0] exp_temp = 12'h000;
  bit rand_temp = 0;
  int avg_n[4] = '{1, 256, 512, 1024};
  wire [13:0] gains = {volt_c_amp_setting, volt_b_amp_setting, volt_a_amp_setting, neutral_amp_setting,
    curr_c_amp_setting, curr_b_amp_setting, curr_a_amp_setting};
  wire [13:0] lgs = {volt_c_gain_log2, volt_b_gain_log2, volt_a_gain_log2, neutral_gain_log2,
    curr_c_gain_log2, curr_b_gain_log2, curr_a_gain_log2};
  wire [6:0] offs = {volt_c_converter_off, volt_b_converter_off, volt_a_converter_off,
    neutral_converter_off, curr_c_converter_off, curr_b_converter_off, curr_a_converter_off};
  mfcr_regs #(.TICK_CYCLES(TICK)) i_dut (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .temp_sensor_value, .temp_reading_fresh, .volt_c_amp_setting, .volt_b_amp_setting,
    .volt_a_amp_setting, .neutral_amp_setting, .curr_c_amp_setting, .curr_b_amp_setting,
    .curr_a_amp_setting, .volt_c_gain_log2, .volt_b_gain_log2, .volt_a_gain_log2, .neutral_gain_log2,
    .curr_c_gain_log2, .curr_b_gain_log2, .curr_a_gain_log2, .volt_c_converter_off,
    .volt_b_converter_off, .volt_a_converter_off, .neutral_converter_off, .curr_c_converter_off,
    .curr_b_converter_off, .curr_a_converter_off, .reactive_total_inhibit);
  initial begin
    forever #2.5 clock = ~clock;
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [10:0] a);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  // Bounded wait for the refresh pulse; n counts cycles waited
  task automatic wait_fresh();
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (temp_reading_fresh !== 1'b1 && n < 5000);
    `CHK(temp_reading_fresh, 1'b1)
  endtask
  task automatic stop_test();
    $display("mismatches %0d, checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Reference model of the averaging window: a tick every TICK cycles, a select write restarts it
  always @(posedge clock) begin
    if (rand_temp) temp_sensor_value <= 12'(rnd());
    if (reset) begin
      t_cnt = 0;
      w_cnt = 0;
      w_sum = 0;
      w_sel = 0;
      q_exp.delete();
    end else begin
      if (temp_reading_fresh === 1'b1) begin
        `CHK(q_exp.size(), 1)
        exp_temp = 12'(q_exp.pop_front());
      end
      if (reg_write && reg_addr == mfcr_pkg::OFS_TEMP_AVG) begin
        w_sel = reg_wdata[1:0];
        w_cnt = 0;
        w_sum = 0;
      end else if (t_cnt == TICK - 1) begin
        w_sum += temp_sensor_value;
        w_cnt++;
        if (w_cnt == avg_n[w_sel]) begin
          q_exp.push_back(w_sum / w_cnt);
          w_cnt = 0;
          w_sum = 0;
        end
      end
      t_cnt = (t_cnt == TICK - 1) ? 0 : t_cnt + 1;
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    #1;
    `CHK({gains, offs, reactive_total_inhibit}, 22'h0)
    foreach (avg_n[i]) begin
      rd(mfcr_pkg::OFS_TEMP_AVG + 11'(i));
      `CHK(rv, 16'h0000)
    end
    rd(mfcr_pkg::OFS_REACTIVE_OFF);
    `CHK(rv, 16'h0000)
    for (int k = 0; k < 5; k++) begin
      r = rnd();
      m_gain = (k < 4) ? {7{2'(k)}} : r[13:0];
      wr(mfcr_pkg::OFS_AMP_GAINS, (k < 4) ? {r[15:14], 14'(m_gain)} : r);
      `CHK(gains, 14'(m_gain))
      if (k < 4) `CHK(lgs, {7{(k > 1) ? 2'h2 : 2'(k)}})
      rd(mfcr_pkg::OFS_AMP_GAINS);
      `CHK(rv, 16'(m_gain))
    end
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      m_shut = (i < 7) ? (1 << i) : r[6:0];
      wr(mfcr_pkg::OFS_CONV_SHUTOFF, {r[15:7], 7'(m_shut)});
      `CHK(offs, 7'(m_shut))
      rd(mfcr_pkg::OFS_CONV_SHUTOFF);
      `CHK(rv, 16'(m_shut))
    end
    for (int b = 0; b < 2; b++) begin
      wr(mfcr_pkg::OFS_REACTIVE_OFF, 16'hFFFE | 16'(b));
      `CHK(reactive_total_inhibit, 1'(b))
      rd(mfcr_pkg::OFS_REACTIVE_OFF);
      `CHK(rv, 16'(b))
    end
    wr(11'h4B8, 16'hFFFF);
    rd(11'h4B8);
    `CHK({rv, gains, offs}, {16'h0000, 14'(m_gain), 7'(m_shut)})
    rand_temp = 1'b1;
    foreach (avg_n[s]) begin
      wr(mfcr_pkg::OFS_TEMP_AVG, 16'hFFFC | 16'(s));
      wait_fresh();
      wait_fresh();
      `CHK(n, avg_n[s] * TICK)
      rd(mfcr_pkg::OFS_TEMP_READING);
      `CHK(rv, 16'(exp_temp))
    end
    wr(mfcr_pkg::OFS_TEMP_READING, 16'hFFFF);
    rd(mfcr_pkg::OFS_TEMP_READING);
    `CHK(rv, 16'(exp_temp))
    stop_test();
  end
endmodule
